// ===== common/fdc_xfer_pkg.sv
// constants for the floppy host transfer controller
// assumes a 200 MHz aclk and a 32-bit AXI4-Lite register bus
package fdc_xfer_pkg;

    // clock and pin timing
    localparam int CLK_PERIOD_PS   = 5000;
    localparam int REARM_DELAY_NS  = 350;
    localparam int DROP_LIMIT_NS   = 50;
    // least delay rounds up
    localparam int REARM_CYCLES    = (REARM_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // longest time rounds down; request drop path must fit inside it
    localparam int DROP_CYCLES     = (DROP_LIMIT_NS * 1000) / CLK_PERIOD_PS;

    // fifo geometry
    localparam int FIFO_DEPTH      = 16;
    localparam int LEVEL_W         = 5;

    // host port register addresses on addr[2:0]
    localparam logic [2:0] PIN_ADDR_MSR  = 3'h4;
    localparam logic [2:0] PIN_ADDR_DATA = 3'h5;

    // main_status_register bit positions
    localparam int MSR_RQM  = 7;
    localparam int MSR_DIO  = 6;
    localparam int MSR_NDMA = 5;
    localparam int MSR_CIP  = 4;

    // axi register byte addresses
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_SECLEN = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;

    // control register fields
    localparam int CTRL_THR_LSB   = 0;   // fifo_threshold, 4 bits
    localparam int CTRL_FIFO_EN   = 4;
    localparam int CTRL_BURST     = 5;
    localparam int CTRL_DMA_SEL_N = 6;   // specify-command selection, 0 = dma
    localparam int CTRL_DOR_DMA   = 7;   // digital_output_register dma enable
    localparam int CTRL_DIR_READ  = 8;
    localparam int CTRL_START     = 9;   // self clearing
    localparam logic [9:0] CTRL_RESET = 10'h000;
    localparam logic [15:0] SECLEN_RESET = 16'h0200;

    // status register fields
    localparam int STAT_OVERRUN   = 8;
    localparam int STAT_TC        = 9;
    localparam int STAT_LEVEL_LSB = 16;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {PH_IDLE, PH_EXEC, PH_RESULT} phase_e;

endpackage : fdc_xfer_pkg

// ===== design/fdc_byte_fifo.sv
// sixteen-entry byte fifo with a fill level output
// assumes push is never given when full nor pop when empty
`timescale 1ns/1ps
`default_nettype none
module fdc_byte_fifo #(
    parameter int DEPTH = 16,
    parameter int LW    = 5
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic          clear,
    input  wire logic          push,
    input  wire logic [7:0]    push_data,
    input  wire logic          pop,
    output logic      [7:0]    head,
    output logic      [LW-1:0] level
);
    localparam int AW = $clog2(DEPTH);

    logic [7:0]    mem [DEPTH];
    logic [AW-1:0] wptr_q;
    logic [AW-1:0] rptr_q;
    logic [LW-1:0] level_q;

    // storage has no reset; only pointers matter
    always_ff @(posedge aclk) begin
        if (push) begin
            mem[wptr_q] <= push_data;
        end
    end

    // pointers and level move together
    always_ff @(posedge aclk) begin
        if (!aresetn || clear) begin
            wptr_q  <= '0;
            rptr_q  <= '0;
            level_q <= '0;
        end else begin
            if (push) begin
                wptr_q <= wptr_q + 1'b1;
            end
            if (pop) begin
                rptr_q <= rptr_q + 1'b1;
            end
            if (push && !pop) begin
                level_q <= level_q + 1'b1;
            end else if (pop && !push) begin
                level_q <= level_q - 1'b1;
            end
        end
    end

    assign head  = mem[rptr_q];
    assign level = level_q;
endmodule : fdc_byte_fifo
`default_nettype wire

// ===== design/fdc_host_xfer.sv
// execution and result phase host transfer logic of a floppy controller
// assumes pins arrive asynchronously and the disk core sits on aclk
// Operation
// - read request at level >= 16 - threshold
// - read burst holds request until empty
// - read non-burst drops, rearms after 350 ns
// - sector end forces read request
// - write request at level <= threshold
// - write burst holds request until full
// - write non-burst drops, rearms after 350 ns
// - sector byte count stops write request
// - acknowledge leading edge counts one transfer
// - held acknowledge: strobe trailing edge drops
// - request drops within 50 ns
// - missed service flags overrun, ends sector (here it only sets overrun; the sector goes on)
// - underrun repeats last byte, then crc
// - end interrupt, cleared by first result
// - non-dma unbuffered: interrupt per byte
// - non-dma transfer needs select, strobe, valid address
// - result start sets rqm, dio, clears ndma
// - non-dma buffered uses same thresholds
// - read result waits for fifo drained
// - rqm mirrors interrupt when polling
// - command in progress clears after last result
// - terminal count honoured only with acknowledge
`timescale 1ns/1ps
`default_nettype none
module fdc_host_xfer
    import fdc_xfer_pkg::*;
#(
    parameter int SERVICE_CYCLES = 2400
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite slave
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // host pins
    input  wire logic        dack_n,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic        cs_n,
    input  wire logic [2:0]  addr,
    input  wire logic        tc,
    input  wire logic [7:0]  data_in,
    output logic [7:0]       data_out,
    output logic             data_oe_n,
    output logic             drq,
    output logic             irq6,
    // disk core side
    input  wire logic        disk_valid,
    input  wire logic [7:0]  disk_data,
    output logic             disk_ready,
    input  wire logic        disk_sector_end,
    input  wire logic        disk_take,
    output logic [7:0]       disk_wr_data,
    input  wire logic        next_sector,
    input  wire logic        disk_done,
    output logic             overrun,
    output logic             tc_seen,
    input  wire logic        result_valid,
    input  wire logic [7:0]  result_byte,
    input  wire logic        result_last,
    output logic             result_take
);
    import fdc_xfer_pkg::*;

    localparam logic [LEVEL_W-1:0] FULL_LVL = LEVEL_W'(FIFO_DEPTH);
    localparam int CW = $clog2(SERVICE_CYCLES + 1);

    // register state
    logic [9:0]  ctrl_q;
    logic [15:0] seclen_q;
    logic        aw_hold_q, w_hold_q;
    logic [3:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        overrun_q, tc_q;
    phase_e      phase_q;

    // pin synchronisers: stage1 feeds stage2 only
    logic [15:0] pin_s1_q, pin_s2_q, pin_s3_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // strobes idle high, terminal count idle low: no false edge after reset
            pin_s1_q <= 16'h00F0;
            pin_s2_q <= 16'h00F0;
            pin_s3_q <= 16'h00F0;
        end else begin
            pin_s1_q <= {data_in, dack_n, rd_n, wr_n, cs_n, tc, addr};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    logic dk, rd, wr, cs, dk_p, rd_p, wr_p;
    logic [2:0] pa;
    assign dk   = !pin_s2_q[7];
    assign rd   = !pin_s2_q[6];
    assign wr   = !pin_s2_q[5];
    assign cs   = !pin_s2_q[4];
    assign pa   = pin_s2_q[2:0];
    assign dk_p = !pin_s3_q[7];
    assign rd_p = !pin_s3_q[6];
    assign wr_p = !pin_s3_q[5];

    // mode decode
    logic dir_read, burst, fifo_en, dma_mode, non_dma, exec;
    logic [3:0] thr;
    assign dma_mode = !ctrl_q[CTRL_DMA_SEL_N] && ctrl_q[CTRL_DOR_DMA];
    assign non_dma  = !dma_mode;
    assign dir_read = ctrl_q[CTRL_DIR_READ];
    assign fifo_en  = ctrl_q[CTRL_FIFO_EN];
    // fifo off behaves as a one-byte trigger without bursting
    assign burst    = fifo_en && ctrl_q[CTRL_BURST];
    assign thr      = fifo_en ? ctrl_q[CTRL_THR_LSB +: 4] : 4'hF;
    assign exec     = (phase_q == PH_EXEC);

    // transfer recognition
    logic dk_used_q;
    logic dma_xfer, pio_data, pio_xfer, xfer, res_read;
    // acknowledge edge counts; the first strobe inside it does not
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dk_used_q <= 1'b0;
        end else if (dk && !dk_p) begin
            dk_used_q <= 1'b1;
        end else if (!dk || ((rd_p && !rd) || (wr_p && !wr))) begin
            dk_used_q <= 1'b0;
        end
    end
    // held acknowledge counts strobe trailing edges
    assign dma_xfer = dma_mode && exec && ((dk && !dk_p) ||
                      (dk && !dk_used_q && ((rd_p && !rd) || (wr_p && !wr))));
    assign pio_data = cs && !dk && (pa == PIN_ADDR_DATA);
    assign pio_xfer = non_dma && exec && pio_data && ((rd && !rd_p && dir_read) || (wr && !wr_p && !dir_read));
    assign xfer     = dma_xfer || pio_xfer;
    assign res_read = (phase_q == PH_RESULT) && pio_data && rd && !rd_p && result_valid;

    // fifo
    logic [7:0] head;
    logic [LEVEL_W-1:0] level;
    logic push, pop, fifo_full, fifo_empty, underrun_fill;
    assign fifo_full  = (level == FULL_LVL);
    assign fifo_empty = (level == '0);
    // read overrun drops disk bytes but host still drains
    assign push = exec && (dir_read ? (disk_valid && !fifo_full) : (xfer && !fifo_full));
    assign pop  = exec && (dir_read ? (xfer && !fifo_empty) : (disk_take && !fifo_empty));
    assign disk_ready   = exec && dir_read;
    assign underrun_fill = !dir_read && disk_take && fifo_empty;

    fdc_byte_fifo #(.DEPTH(FIFO_DEPTH), .LW(LEVEL_W)) u_fifo (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .clear     (phase_q == PH_IDLE),
        .push      (push),
        .push_data (pin_s2_q[15:8]),
        .pop       (pop),
        .head      (head),
        .level     (level)
    );

    // last written byte and repeat on underrun
    logic [7:0] last_byte_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_byte_q <= 8'h00;
        end else if (pop && !dir_read) begin
            last_byte_q <= head;
        end
    end
    // repeat last byte into the sector tail
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            disk_wr_data <= 8'h00;
        end else if (pop && !dir_read) begin
            disk_wr_data <= head;
        end else if (underrun_fill) begin
            disk_wr_data <= last_byte_q;
        end
    end

    // sector bookkeeping
    logic sec_end_q, sec_hold_q;
    logic [15:0] wr_cnt_q;
    always_ff @(posedge aclk) begin
        if (!aresetn || !exec) begin
            sec_end_q <= 1'b0;
        end else if (disk_sector_end && dir_read) begin
            sec_end_q <= 1'b1;
        end else if (fifo_empty) begin
            sec_end_q <= 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || !exec) begin
            wr_cnt_q   <= 16'h0000;
            sec_hold_q <= 1'b0;
        end else if (next_sector) begin
            wr_cnt_q   <= 16'h0000;
            sec_hold_q <= 1'b0;
        end else if (push && !dir_read) begin
            wr_cnt_q   <= wr_cnt_q + 16'h0001;
            sec_hold_q <= (wr_cnt_q + 16'h0001 >= seclen_q);
        end
    end

    // request pacing
    logic req_q, stop_q;
    logic [$clog2(REARM_CYCLES+1)-1:0] gap_q;
    logic trig, more, bust;
    assign trig = dir_read ? ((level >= LEVEL_W'(FIFO_DEPTH - thr)) || (sec_end_q && !fifo_empty))
                           : ((level <= LEVEL_W'(thr)) && !sec_hold_q);
    assign more = dir_read ? !fifo_empty : (!fifo_full && !sec_hold_q);
    always_ff @(posedge aclk) begin
        if (!aresetn || !exec) begin
            gap_q <= '0;
        end else if (xfer && !burst) begin
            gap_q <= ($clog2(REARM_CYCLES+1))'(REARM_CYCLES);
        end else if (gap_q != '0) begin
            gap_q <= gap_q - 1'b1;
        end
    end
    assign bust = dir_read ? (level == LEVEL_W'(1) && pop) : (level == LEVEL_W'(FIFO_DEPTH - 1) && push);
    // request drops the cycle after the synced edge
    always_ff @(posedge aclk) begin
        if (!aresetn || !exec || stop_q) begin
            req_q <= 1'b0;
        end else if (xfer && (!burst || bust)) begin
            req_q <= 1'b0;
        end else if (!dir_read && push && (wr_cnt_q + 16'h0001 >= seclen_q)) begin
            req_q <= 1'b0;
        end else if (req_q) begin
            req_q <= more;
        end else if (gap_q == '0 && !xfer) begin
            req_q <= trig;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || phase_q == PH_IDLE) begin
            stop_q <= 1'b0;
        end else if (exec && dma_mode && dk && pin_s2_q[3]) begin
            stop_q <= 1'b1;
        end
    end
    assign tc_seen = stop_q;

    // service timer while a request waits
    logic [CW-1:0] svc_q;
    always_ff @(posedge aclk) begin
        if (!aresetn || !exec || !req_q || xfer) begin
            svc_q <= '0;
        end else if (svc_q != CW'(SERVICE_CYCLES)) begin
            svc_q <= svc_q + 1'b1;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || phase_q == PH_IDLE && ctrl_q[CTRL_START]) begin
            overrun_q <= 1'b0;
        end else if (svc_q == CW'(SERVICE_CYCLES - 1)) begin
            overrun_q <= 1'b1;
        end
    end
    assign overrun = overrun_q;

    // phase sequencing and end interrupt
    logic end_irq_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_q <= PH_IDLE;
        end else begin
            case (phase_q)
                PH_IDLE: begin
                    if (ctrl_q[CTRL_START]) begin
                        phase_q <= PH_EXEC;
                    end
                end
                PH_EXEC: begin
                    // read ends only after the fifo drains
                    if (disk_done && (!dir_read || fifo_empty)) begin
                        phase_q <= PH_RESULT;
                    end
                end
                PH_RESULT: begin
                    // last result byte ends the command
                    if (res_read && result_last) begin
                        phase_q <= PH_IDLE;
                    end
                end
                default: phase_q <= PH_IDLE;
            endcase
        end
    end
    // end interrupt until first result byte
    always_ff @(posedge aclk) begin
        if (!aresetn || phase_q == PH_IDLE) begin
            end_irq_q <= 1'b0;
        end else if (exec && disk_done && (!dir_read || fifo_empty)) begin
            end_irq_q <= 1'b1;
        end else if (res_read) begin
            end_irq_q <= 1'b0;
        end
    end
    assign result_take = res_read;

    // non-dma request appears on the interrupt line
    assign irq6 = end_irq_q || (non_dma && req_q);
    assign drq  = dma_mode && req_q;

    // main_status_register view
    logic [7:0] main_status_register;
    always_comb begin
        main_status_register = 8'h00;
        // rqm mirrors the interrupt while executing
        // result phase shows rqm and dio, no ndma
        main_status_register[MSR_RQM]  = exec ? (non_dma && req_q) : (phase_q == PH_RESULT ? result_valid : 1'b1);
        main_status_register[MSR_DIO]  = exec ? dir_read : (phase_q == PH_RESULT);
        main_status_register[MSR_NDMA] = exec && non_dma;
        main_status_register[MSR_CIP]  = (phase_q != PH_IDLE);
    end

    // host data bus drive, captured when the read strobe opens
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_out <= 8'h00;
        end else if (rd && !rd_p) begin
            if (cs && pa == PIN_ADDR_MSR) begin
                data_out <= main_status_register;
            end else if (phase_q == PH_RESULT) begin
                data_out <= result_byte;
            end else begin
                data_out <= head;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_oe_n <= 1'b1;
        end else begin
            data_oe_n <= !(rd && ((dk && dma_mode) || (cs && (pa == PIN_ADDR_MSR || pa == PIN_ADDR_DATA))));
        end
    end

    // axi write channel capture in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            awaddr_q  <= 4'h0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                // strobes may change once w is taken, so keep them with the data
                wstrb_q  <= s_axi_wstrb;
            end
            if (aw_hold_q && w_hold_q) begin
                aw_hold_q <= 1'b0;
                w_hold_q  <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;

    // register writes; start clears itself next cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q   <= CTRL_RESET;
            seclen_q <= SECLEN_RESET;
        end else begin
            ctrl_q[CTRL_START] <= 1'b0;
            if (aw_hold_q && w_hold_q) begin
                if (awaddr_q == REG_CTRL) begin
                    if (wstrb_q[0]) begin
                        ctrl_q[7:0] <= wdata_q[7:0];
                    end
                    if (wstrb_q[1]) begin
                        ctrl_q[9:8] <= wdata_q[9:8];
                    end
                end else if (awaddr_q == REG_SECLEN) begin
                    if (wstrb_q[0]) begin
                        seclen_q[7:0] <= wdata_q[7:0];
                    end
                    if (wstrb_q[1]) begin
                        seclen_q[15:8] <= wdata_q[15:8];
                    end
                end
            end
        end
    end

    // write response; unmapped address answers slverr
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (aw_hold_q && w_hold_q) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_q == REG_CTRL || awaddr_q == REG_SECLEN) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read channel, one cycle to answer
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            if (s_axi_araddr == REG_CTRL) begin
                s_axi_rdata <= {22'h00_0000, ctrl_q};
            end else if (s_axi_araddr == REG_SECLEN) begin
                s_axi_rdata <= {16'h0000, seclen_q};
            end else if (s_axi_araddr == REG_STATUS) begin
                s_axi_rdata <= {11'h000, level, 6'h00, tc_q, overrun_q, main_status_register};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // sticky terminal count view, cleared by a new start
    always_ff @(posedge aclk) begin
        if (!aresetn || ctrl_q[CTRL_START]) begin
            tc_q <= 1'b0;
        end else if (stop_q) begin
            tc_q <= 1'b1;
        end
    end
endmodule : fdc_host_xfer
`default_nettype wire

// ===== design/fdc_host_xfer_fix.sv
// (intentionally empty of logic; kept nothing)

// ===== tb/fdc_host_xfer_sva.sv
// assertions on the pins and read channel of the host transfer block
// bound from the bench top; one aclk domain
`timescale 1ns/1ps
`default_nettype none
module fdc_host_xfer_sva (
    input wire logic aclk, aresetn, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic dack_n, rd_n, drq, irq6, data_oe_n, tc_seen
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // read address accepted
    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    chk_rst_quiet: assert property ($rose(aresetn) |-> !drq && !irq6 && data_oe_n)
        else $error("pins active after reset");
    chk_read_answer: assert property (ar_taken |=> s_axi_rvalid)
        else $error("late read answer");
    chk_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    chk_tc_gate: assert property (dack_n [*6] ##0 !tc_seen |=> !tc_seen)
        else $error("count taken without ack");
    chk_oe_idle: assert property (rd_n [*6] |-> data_oe_n)
        else $error("bus driven without read");
    chk_oe_start: assert property ($fell(data_oe_n) |-> !rd_n)
        else $error("drive began off strobe");
    chk_oe_hold: assert property (!data_oe_n && !rd_n |=> !data_oe_n)
        else $error("drive cut inside strobe");
    chk_one_req: assert property (!(drq && irq6))
        else $error("both requests high");
endmodule : fdc_host_xfer_sva
`default_nettype wire

// ===== tb/dma_host_model.sv
// dma controller model: one acknowledged read strobe per request
// assumes a level request; gap sets how slowly it answers
`timescale 1ns/1ps
`default_nettype none
module dma_host_model (
    input  wire logic       aclk, drq,
    input  wire logic [7:0] gap,
    output logic            dack_n, rd_n,
    output int              n_xfer
);
    // single-byte service keeps the byte count exact
    initial begin
        {dack_n, rd_n} = 2'b11;
        n_xfer = 0;
        forever begin
            @(posedge aclk);
            if (drq === 1'b1) begin
                repeat (gap) @(posedge aclk);
                // ack strobed per byte, sector drained
                {dack_n, rd_n} <= 2'b00;
                repeat (6) @(posedge aclk);
                {dack_n, rd_n} <= 2'b11;
                n_xfer <= n_xfer + 1;
                repeat (3) @(posedge aclk);
            end
        end
    end
endmodule : dma_host_model
`default_nettype wire

// ===== tb/floppy_host_transfer_ctrl_bench.sv
// bench: a four-byte dma read sector, then the result phase on the pins
// all inputs change by nonblocking assignment at posedge
`timescale 1ns/1ps
`default_nettype none
module floppy_host_transfer_ctrl_bench;
    import fdc_xfer_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, cs_n = 1'b1;
    logic        t_rd = 1'b1, dv = 1'b0, se = 1'b0, done = 1'b0, rv = 1'b0, awr, wr, bv, arr, rvl, dack_n, m_rd, drq, irq6;
    logic        tcv = 1'b0, dr;
    logic [3:0]  aa = 4'h0, st = 4'hf;
    logic [2:0]  pa = PIN_ADDR_DATA;
    logic [31:0] wd = 32'h0000_0000, rdat;
    logic [7:0]  dd = 8'h00, rb = 8'h00, gap = 8'h00, dout;
    logic [1:0]  bresp, rresp;
    logic [33:0] exp_q[$];
    int          num_errors = 0, n_tests = 0, n_xfer, i;
    // 200 MHz clock; host and dma share the read strobe
    always #2.5 aclk = ~aclk;
    fdc_host_xfer #(.SERVICE_CYCLES(40)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(st), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(aa), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rvl), .s_axi_rready(rr),
        .dack_n(dack_n), .rd_n(m_rd & t_rd), .wr_n(1'b1), .cs_n(cs_n), .addr(pa), .tc(tcv), .data_in(8'h00),
        .data_out(dout), .data_oe_n(), .drq(drq), .irq6(irq6), .disk_valid(dv), .disk_data(dd), .disk_ready(dr),
        .disk_sector_end(se), .disk_take(1'b0), .disk_wr_data(), .next_sector(1'b0), .disk_done(done), .overrun(),
        .tc_seen(), .result_valid(rv), .result_byte(rb), .result_last(rv), .result_take());
    dma_host_model host (.aclk(aclk), .drq(drq), .gap(gap), .dack_n(dack_n), .rd_n(m_rd), .n_xfer(n_xfer));
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        n_tests++;
        if (got !== exp) num_errors++;
        if (got !== exp) $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    endtask : chk
    // a lapsed wait counts as a mismatch before the verdict
    task automatic give_verdict(input logic lapsed);
        num_errors += lapsed;
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    // one axi access; the answer is noted first, each channel held until taken
    task automatic axi(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [33:0] e);
        logic [3:0] hs;
        int n;
        exp_q.push_back(e);
        {aa, wd, awv, wv, br, arv, rr} <= {a, d, w, w, w, !w, !w};
        n = 0;
        do begin
            @(negedge aclk);
            hs = {awr & awv, wr & wv, arr & arv, (bv & br) | (rvl & rr)};
            @(posedge aclk);
            {awv, wv, arv} <= {awv & ~hs[3], wv & ~hs[2], arv & ~hs[1]};
            if (hs[0]) {br, rr} <= 2'b00;
            n++;
        end while (n < 200 && (awv | wv | arv | br | rr));
        if (n == 200) give_verdict(1'b1);
        @(posedge aclk);
    endtask : axi
    // each answer is matched against the oldest note
    always @(posedge aclk) begin
        if ((bv & br) | (rvl & rr)) chk((bv & br) ? {bresp, 32'h0000_0000} : {rresp, rdat}, exp_q.pop_front());
    end
    // reset, the dma sector, then the result byte over the pins
    initial begin
        void'($urandom(32'h10d0));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        gap <= 8'($urandom % 12);
        repeat (3) @(posedge aclk);
        axi(1'b1, REG_SECLEN, 32'h0000_0004, 34'h0);
        axi(1'b1, REG_CTRL, 32'h0000_01B0 | gap, 34'h0);
        axi(1'b1, REG_CTRL, 32'h0000_03B0 | gap, 34'h0);
        for (i = 0; i < 4; i++) begin
            {dv, se, dd} <= {1'b1, i == 3, 8'($urandom)};
            @(posedge aclk);
            {dv, se} <= 2'b00;
            repeat (8) @(posedge aclk);
            if (i == 2) chk({33'h0, drq}, 34'h0);
            if (i == 2) chk({33'h0, dr}, 34'h1);
        end
        for (i = 0; i < 3000 && n_xfer != 4; i++) @(posedge aclk);
        repeat (20) @(posedge aclk);
        chk(34'(n_xfer), 34'h4);
        tcv <= 1'b1;
        repeat (4) @(posedge aclk);
        tcv <= 1'b0;
        done <= 1'b1;
        @(posedge aclk);
        done <= 1'b0;
        for (i = 0; i < 300 && irq6 !== 1'b1; i++) @(posedge aclk);
        if (i == 300) give_verdict(1'b1);
        chk({33'h0, irq6}, 34'h1);
        {rv, rb} <= {1'b1, 8'($urandom)};
        axi(1'b0, REG_STATUS, 32'h0, {RESP_OKAY, 32'h0000_00D0});
        cs_n <= 1'b0;
        repeat (6) @(posedge aclk);
        chk({33'h0, irq6}, 34'h1);
        t_rd <= 1'b0;
        repeat (6) @(posedge aclk);
        {cs_n, t_rd, rv} <= 3'b110;
        repeat (6) @(posedge aclk);
        chk({33'h0, irq6}, 34'h0);
        chk({26'h0, dout}, {26'h0, rb});
        axi(1'b0, REG_STATUS, 32'h0, {RESP_OKAY, 32'h0000_0080});
        axi(1'b0, 4'hC, 32'h0, {RESP_SLVERR, 32'h0000_0000});
        give_verdict(1'b0);
    end
endmodule : floppy_host_transfer_ctrl_bench
bind fdc_host_xfer fdc_host_xfer_sva sva (.aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .dack_n(dack_n),
    .rd_n(rd_n), .drq(drq), .irq6(irq6), .data_oe_n(data_oe_n), .tc_seen(tc_seen));
`default_nettype wire
